// ===== rtl/den_enable_reg.v
// digital enable register: channel enables and fifo clock gating
// assumes a serial host front end delivering single-cycle byte writes/reads
// Function
// RULE_01: upper nibble enables X, Y, Z, temperature
// RULE_02: valid channel settings go to all blocks
// RULE_03: fifo disabled stops fifo and memory clocks
// RULE_04: fifo enabled runs clock, normal operation
// RULE_05: register at 0x27, resets to zero
// RULE_06: invalid channel combination is ignored downstream
`timescale 1ns/1ps
`include "den_map.vh"
module den_enable_reg #(
	parameter ADDR_W = `DEN_ADDR_W
) (
	clk,
	arst_n,
	reg_addr,
	reg_wr,
	reg_wdata,
	reg_rd,
	reg_rdata,
	reg_value,
	x_en,
	y_en,
	z_en,
	temp_en,
	fifo_en,
	fifo_clk,
	cfg_invalid
);
	input  wire              clk;
	input  wire              arst_n;
	input  wire [ADDR_W-1:0] reg_addr;
	input  wire              reg_wr;
	input  wire [7:0]        reg_wdata;
	input  wire              reg_rd;
	output reg  [7:0]        reg_rdata;
	output reg  [7:0]        reg_value;
	output reg               x_en;
	output reg               y_en;
	output reg               z_en;
	output reg               temp_en;
	output reg               fifo_en;
	output wire              fifo_clk;
	output reg               cfg_invalid;

	// reset image split per field, so the logic holds no bare values
	localparam [7:0]        RESET_IMAGE   = `DEN_RESET_VAL;
	localparam [3:0]        RESET_CH      = RESET_IMAGE[`DEN_CH_MSB:`DEN_CH_LSB];
	localparam [0:0]        RESET_FIFO    = RESET_IMAGE[`DEN_FIFO_BIT];
	localparam [0:0]        RESET_INVALID = 1'b0;

	// the one address this block answers on
	localparam [ADDR_W-1:0] ENABLE_ADDR   = `DEN_REG_ENABLE;

	// decode nets
	wire                    wr_hit;
	wire                    rd_hit;
	wire [3:0]              ch_wr;
	wire                    ch_ok;
	wire [3:0]              ch_q;

	// next values, settled before each rising edge
	reg  [7:0]              value_d;
	reg  [3:0]              ch_d;
	reg                     fifo_d;
	reg                     invalid_d;
	reg  [7:0]              rdata_d;

	// a combination is valid when at least one channel is selected
	function ch_valid;
		input [3:0] ch;
		begin
			ch_valid = (ch != `DEN_CH_NONE);
		end
	endfunction

	// address decode shared by the write and the read path
	function addr_hit;
		input [ADDR_W-1:0] addr;
		begin
			addr_hit = (addr == ENABLE_ADDR);
		end
	endfunction

	// strobes qualified by the address; channel nibble of the write data
	assign wr_hit = reg_wr & addr_hit(reg_addr); // [RULE_05]
	assign rd_hit = reg_rd & addr_hit(reg_addr); // [RULE_05]
	assign ch_wr  = reg_wdata[`DEN_CH_MSB:`DEN_CH_LSB]; // [RULE_01]
	assign ch_ok  = ch_valid(ch_wr);
	assign ch_q   = {temp_en, z_en, y_en, x_en};

	// next-value logic below; every path assigns, so no latch can form

	// next stored byte: raw write data, so readback shows what was written
	always @* begin
		value_d = reg_value;
		if (wr_hit) begin
			value_d = reg_wdata;
		end
	end

	// next applied channels: only a valid nibble reaches the blocks
	always @* begin
		ch_d = ch_q;
		if (wr_hit) begin
			if (ch_ok) begin
				ch_d = ch_wr; // [RULE_01] [RULE_02]
			end else begin
				ch_d = ch_q; // [RULE_06]
			end
		end
	end

	// invalid flag tells software its last nibble was not applied
	always @* begin
		invalid_d = cfg_invalid;
		if (wr_hit) begin
			invalid_d = ~ch_ok; // [RULE_06]
		end
	end

	// fifo enable follows its bit whatever the channel nibble holds
	always @* begin
		fifo_d = fifo_en;
		if (wr_hit) begin
			fifo_d = reg_wdata[`DEN_FIFO_BIT]; // [RULE_03] [RULE_04]
		end
	end

	// read data: a hit shows the stored byte, other addresses read zero
	always @* begin
		rdata_d = reg_rdata;
		if (reg_rd) begin
			if (rd_hit) begin
				rdata_d = reg_value;
			end else begin
				rdata_d = `DEN_READ_UNMAPPED;
			end
		end
	end

	// registered outputs: one process each keeps every reset value in view

	// stored byte
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_value <= RESET_IMAGE; // [RULE_05]
		end else begin
			reg_value <= value_d;
		end
	end

	// x axis enable
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			x_en <= RESET_CH[`DEN_CH_X]; // [RULE_05]
		end else begin
			x_en <= ch_d[`DEN_CH_X]; // [RULE_01] [RULE_02]
		end
	end

	// y axis enable
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			y_en <= RESET_CH[`DEN_CH_Y]; // [RULE_05]
		end else begin
			y_en <= ch_d[`DEN_CH_Y]; // [RULE_01] [RULE_02]
		end
	end

	// z axis enable
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			z_en <= RESET_CH[`DEN_CH_Z]; // [RULE_05]
		end else begin
			z_en <= ch_d[`DEN_CH_Z]; // [RULE_01] [RULE_02]
		end
	end

	// temperature channel enable
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			temp_en <= RESET_CH[`DEN_CH_TEMP]; // [RULE_05]
		end else begin
			temp_en <= ch_d[`DEN_CH_TEMP]; // [RULE_01] [RULE_02]
		end
	end

	// invalid combination flag
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_invalid <= RESET_INVALID;
		end else begin
			cfg_invalid <= invalid_d; // [RULE_06]
		end
	end

	// applied fifo enable
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fifo_en <= RESET_FIFO; // [RULE_03] [RULE_05]
		end else begin
			fifo_en <= fifo_d; // [RULE_03] [RULE_04]
		end
	end

	// read data register, holds until the next read
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= RESET_IMAGE;
		end else begin
			reg_rdata <= rdata_d;
		end
	end

	// gated fifo clock: stopped while disabled, running when enabled;
	// it leaves through a gate, not a flop, since it is a clock
	den_clk_gate u_gate (
		.clk    (clk),
		.arst_n (arst_n),
		.en     (fifo_en), // [RULE_03] [RULE_04]
		.gclk   (fifo_clk)
	);
endmodule // den_enable_reg

// ===== rtl/den_map.vh
// register map constants for the digital enable register block
// assumes inclusion by bare name from the design files
`ifndef DEN_MAP_VH
`define DEN_MAP_VH
`define DEN_ADDR_W          8
`define DEN_DATA_W          8
`define DEN_REG_ENABLE      8'h27
`define DEN_RESET_VAL       8'h00
`define DEN_CH_LSB          4
`define DEN_CH_MSB          7
`define DEN_FIFO_BIT        3
`define DEN_CH_X            0
`define DEN_CH_Y            1
`define DEN_CH_Z            2
`define DEN_CH_TEMP         3
`define DEN_CH_NONE         4'h0
`define DEN_READ_UNMAPPED   8'h00
`endif

// ===== rtl/den_clk_gate.v
// clock gate for the fifo and fifo memory clocks
// assumes clk runs free and arst_n is the block reset
`timescale 1ns/1ps
module den_clk_gate (
	clk,
	arst_n,
	en,
	gclk
);
	input  wire clk;
	input  wire arst_n;
	input  wire en;
	output wire gclk;

	reg         en_q;

	// enable retimed on the falling edge, so it only moves while clk is low;
	// no latch and no cut pulse, at the cost of half a cycle of delay
	always @(negedge clk or negedge arst_n) begin
		if (!arst_n) begin
			en_q <= 1'b0;
		end else begin
			en_q <= en;
		end
	end

	// gated clock stays low while the retimed enable is low
	assign gclk = clk & en_q; // [RULE_03] [RULE_04]
endmodule // den_clk_gate

// ===== testbench/den_chk.sv
// checker for the enable register
// bound into den_enable_reg; sees only its ports, both edges of clk
`timescale 1ns/1ps
module den_chk (
	input wire       clk,
	input wire       arst_n,
	input wire [7:0] reg_addr,
	input wire       reg_wr,
	input wire [7:0] reg_wdata,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire [7:0] reg_value,
	input wire       x_en,
	input wire       y_en,
	input wire       z_en,
	input wire       temp_en,
	input wire       fifo_en,
	input wire       fifo_clk,
	input wire       cfg_invalid
);
	// write to the enable register, and the applied channel nibble
	wire       w = reg_wr && (reg_addr == 8'h27);
	wire [3:0] c = {temp_en, z_en, y_en, x_en};
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	store_wr_a: assert property (w |=> reg_value == $past(reg_wdata))
		else $error("stored byte differs from written byte");
	value_hold_a: assert property (!w |=> $stable(reg_value))
		else $error("stored byte moved without a write");
	ch_map_a: assert property (w && (reg_wdata[7:4] != 4'h0) |=>
		(c == $past(reg_wdata[7:4])) && !cfg_invalid) else $error("channel enables wrong");
	bad_hold_a: assert property (w && (reg_wdata[7:4] == 4'h0) |=>
		$stable(c) && cfg_invalid) else $error("invalid nibble was applied");
	fifo_run_a: assert property (w |=> fifo_en == $past(reg_wdata[3]))
		else $error("fifo enable differs from written bit");
	rd_data_a: assert property (reg_rd |=>
		reg_rdata == (($past(reg_addr) == 8'h27) ? $past(reg_value) : 8'h00))
		else $error("read data differs from stored byte");
	clk_off_a: assert property (@(negedge clk) !$past(fifo_en) |-> !fifo_clk)
		else $error("fifo clock pulses while disabled");
	clk_run_a: assert property (@(negedge clk) $past(fifo_en) |-> fifo_clk)
		else $error("fifo clock missing while enabled");
endmodule // den_chk
bind den_enable_reg den_chk u_chk (
	.clk         (clk),
	.arst_n      (arst_n),
	.reg_addr    (reg_addr),
	.reg_wr      (reg_wr),
	.reg_wdata   (reg_wdata),
	.reg_rd      (reg_rd),
	.reg_rdata   (reg_rdata),
	.reg_value   (reg_value),
	.x_en        (x_en),
	.y_en        (y_en),
	.z_en        (z_en),
	.temp_en     (temp_en),
	.fifo_en     (fifo_en),
	.fifo_clk    (fifo_clk),
	.cfg_invalid (cfg_invalid)
);

// ===== testbench/tb_top.sv
// bench for the enable register
// assumes dut ports match bench names
`timescale 1ns/1ps
module tb_top;
	logic        clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, r = 1'h0, inv = 1'h0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, reg_value, v = 8'h00;
	logic [3:0]  ch = 4'h0;
	logic        x_en, y_en, z_en, temp_en, fifo_en, fifo_clk, cfg_invalid;
	logic [21:0] q[$];
	int          failures = 0, num_checks = 0;
	den_enable_reg dut (
		.clk         (clk),
		.arst_n      (arst_n),
		.reg_addr    (reg_addr),
		.reg_wr      (reg_wr),
		.reg_wdata   (reg_wdata),
		.reg_rd      (reg_rd),
		.reg_rdata   (reg_rdata),
		.reg_value   (reg_value),
		.x_en        (x_en),
		.y_en        (y_en),
		.z_en        (z_en),
		.temp_en     (temp_en),
		.fifo_en     (fifo_en),
		.fifo_clk    (fifo_clk),
		.cfg_invalid (cfg_invalid)
	);
	// everything a read shows, stored byte included
	wire [21:0]  seen = {reg_rdata, reg_value, temp_en, z_en, y_en, x_en, fifo_en, cfg_invalid};
	initial forever #5 clk = ~clk;
	task chk(input [21:0] s, e);
		num_checks++;
		if(s!==e)begin
			failures++;
			$display("BAD %0t %h %h",$time,s,e);
		end
	endtask
	task give_verdict;
		$display("checks %0d failures %0d",num_checks,failures);
		if(failures==0&&num_checks>0)$display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// model moves with each bus cycle; invalid nibble keeps old channels
	task op(input w,input [7:0] a,d);
		if (!w) q.push_back({(a == 8'h27) ? v : 8'h00, v, ch, v[3], inv});
		else if (a == 8'h27) {v, inv, ch} = {d, ~|d[7:4], (|d[7:4]) ? d[7:4] : ch};
		@(negedge clk);
		{reg_wr,reg_rd,reg_addr,reg_wdata}={w,!w,a,d};
		@(negedge clk);
		{reg_wr,reg_rd}=0;
	endtask
	// read data lands one cycle after the strobe
	always @(posedge clk)r<=reg_rd;
	always @(negedge clk) if (r) chk(seen, q.pop_front());
	initial begin
		void'($urandom(67));
		repeat(3)@(negedge clk);
		arst_n=1;
		op(0,8'h27,0);
		repeat(30)begin
			op(1,8'h27,8'($urandom));
			op(0,8'h27,0);
		end
		op(1,8'h27,8'h08);
		op(0,8'h27,0);
		op(1,8'h26,8'hFF);
		op(0,8'h26,0);
		// mid-run reset clears every field again
		@(negedge clk);
		arst_n = 1'h0;
		{v, inv, ch} = 13'h0000;
		repeat (3) @(negedge clk);
		arst_n = 1'h1;
		op(0, 8'h27, 8'h00);
		op(1, 8'h27, 8'h08);
		op(0, 8'h27, 8'h00);
		op(1, 8'h27, 8'h10);
		op(0, 8'h27, 8'h00);
		@(negedge clk);
		give_verdict;
	end
endmodule // tb_top
